// ===== bench/hfd_conditioning_bench.sv
// Self-checking bench for the field conditioning chain.
// Uses an eight-cycle sample divider to keep the run short.
`timescale 1ns/1ns
module hfd_conditioning_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic signed [15:0] adc = 16'sh0000;
   logic ovv = 1'b0;
   logic perr = 1'b0;
   logic [3:0] pline = 4'h0;
   logic [31:0] rdata;
   logic [1:0] span;
   logic vld;
   logic [15:0] res;
   logic [3:0] st;
   logic oe;
   logic [15:0] last_res;
   logic [31:0] frames;
   logic [31:0] rv;
   logic clp;
   int e;
   int err_total = 0;
   int checks = 0;
   int rst_v[6] = '{1, 'h5000, 'h4000, 7, 'h3F00, 0};
   int spn[4] = '{3, 1, 0, 2};
   int spx[4] = '{3, 1, 0, 1};
   int xs[7] = '{1000, 1000, 1000, 32767, 1000, 5000, -2000};
   int gs[7] = '{'h5000, 'h3000, 'h3000, 'h7FFF, 'h5000, 'h5000, 'h3000};
   int os[7] = '{'h4064, 'h5388, 'h4000, 'h7FFF, 'h4064, 'h4000, 'h4000};
   int ls[7] = '{'h3F00, 'h3F00, 'h3F00, 'h3F00, 'h3F02, 'h0300, 'h3F00};
   always #5 clk = ~clk;
   hfd_conditioning #(.SAMPLE_DIV(8)) DUT (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_en), .i_rd(rd_en), .o_rdata(rdata), .i_adc_sample(adc),
      .i_overvolt(ovv), .i_par_err(perr), .i_par_line(pline), .o_adc_span(span),
      .o_result_valid(vld), .o_result(res), .o_status(st), .o_drive_oe(oe)
   );
   hfd_frame_sink u_sink (.i_core_clk(clk), .i_rst_b(rst_b), .i_valid(vld),
      .i_result(res), .o_last_result(last_res), .o_frames(frames));
   function automatic int exp_res(input int x, input int g, input int o, input int l,
                                  output logic c);
      int s;
      int lo;
      int hi;
      lo = l % 64;
      hi = l / 256;
      s = ((x * (g - 16384)) >>> 12) + o - 16384;
      s = (s < 0) ? 0 : ((s > 65535) ? 65535 : s);
      c = 1'b0;
      if (lo != 0 && s < lo * 1024) begin
         s = lo * 1024;
         c = 1'b1;
      end else if (hi != 63 && s > hi * 1024 + 1023) begin
         s = hi * 1024 + 1023;
         c = 1'b1;
      end
      return s;
   endfunction : exp_res
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t mismatch got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd
   // Bounded wait for the next result pulse
   task automatic wv;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (vld !== 1'b1 && n < 40);
      if (n >= 40) err_total++;
   endtask : wv
   task automatic par(input logic [3:0] l);
      @(posedge clk);
      perr <= 1'b1;
      pline <= l;
      @(posedge clk);
      perr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : par
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   initial begin
      #900000;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         bus_rd(4'(k), rv);
         chk(rv, 32'(rst_v[k]));
      end
      bus_rd(4'h8, rv);
      chk(rv, 32'h0);
      bus_wr(4'h5, 32'hF);
      bus_rd(4'h5, rv);
      chk(rv, 32'h0);
      for (int k = 0; k < 4; k++) begin
         bus_wr(4'h0, 32'(spn[k]));
         @(posedge clk);
         #1;
         chk(32'(span), 32'(spx[k]));
      end
      bus_wr(4'h0, 32'h1);
      for (int k = 0; k < 7; k++) begin
         @(posedge clk);
         adc <= 16'(xs[k]);
         bus_wr(4'h1, 32'(gs[k]));
         bus_wr(4'h2, 32'(os[k]));
         bus_wr(4'h4, 32'(ls[k]));
         e = exp_res(xs[k], gs[k], os[k], ls[k], clp);
         wv();
         wv();
         @(posedge clk);
         #1;
         chk(32'(last_res), 32'(e));
         chk(32'(st[3]), 32'(clp));
      end
      bus_wr(4'h1, 32'h5000);
      bus_wr(4'h2, 32'h4000);
      bus_wr(4'h4, 32'h3F00);
      for (int b = 0; b < 7; b++) begin
         @(posedge clk);
         adc <= (b % 2) ? 16'sh07D0 : 16'sh0FA0;
         bus_wr(4'h3, 32'(b));
         repeat (900) wv();
         @(posedge clk);
         #1;
         e = (b % 2) ? 2000 : 4000;
         chk(32'(last_res > e - 128 && last_res < e + 128), 32'h1);
      end
      @(posedge clk);
      ovv <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(32'(st[0]), 32'h1);
      chk(32'(oe), 32'h0);
      @(posedge clk);
      ovv <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(32'(oe), 32'h1);
      par(4'h3);
      chk(32'(st[2:1]), 32'h1);
      par(4'h3);
      chk(32'(st[2:1]), 32'h1);
      par(4'h5);
      chk(32'(st[2:1]), 32'h3);
      repeat (20) @(posedge clk);
      #1;
      chk(32'(oe), 32'h0);
      bus_rd(4'h5, rv);
      chk(rv & 32'h7, 32'h6);
      chk(32'(frames > 0), 32'h1);
      end_sim();
   end
endmodule : hfd_conditioning_bench
bind hfd_conditioning hfd_conditioning_properties #(.SAMPLE_DIV(SAMPLE_DIV)) u_props (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_overvolt(i_overvolt), .i_par_err(i_par_err),
   .o_adc_span(o_adc_span), .o_result_valid(o_result_valid), .o_status(o_status),
   .o_drive_oe(o_drive_oe));

// ===== bench/hfd_conditioning_properties.sv
// Port checker for the conditioning chain.
// Bound to the top module from the bench; sees its ports only.
`timescale 1ns/1ns
module hfd_conditioning_properties #(
   parameter int SAMPLE_DIV = 8
) (
   input logic i_core_clk,
   input logic i_rst_b,
   input logic [3:0] i_addr,
   input logic [31:0] i_wdata,
   input logic i_wr,
   input logic i_overvolt,
   input logic i_par_err,
   input logic [1:0] o_adc_span,
   input logic o_result_valid,
   input logic [3:0] o_status,
   input logic o_drive_oe
);
   logic [15:0] gap_reg;
   logic seen_reg;
   logic [1:0] span_reg;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   sequence span_write;
      i_wr && i_addr == 4'h0;
   endsequence
   always_ff @(posedge i_core_clk) begin
      gap_reg <= (!i_rst_b || o_result_valid) ? 16'h0000 : gap_reg + 16'h0001;
   end
   // The first pulse after reset has no predecessor to measure from
   always_ff @(posedge i_core_clk) begin
      seen_reg <= i_rst_b && (seen_reg || o_result_valid);
   end
   always_ff @(posedge i_core_clk) begin
      if (i_wr && i_addr == 4'h0) begin
         span_reg <= (i_wdata[1:0] == 2'h2) ? 2'h1 : i_wdata[1:0];
      end
   end
   a_span_code: assert property (span_write |=> ##1 o_adc_span == span_reg)
      else $error("span output wrong");
   a_span_unused: assert property (o_adc_span != 2'h2)
      else $error("unused span code driven");
   a_sample_gap: assert property (o_result_valid && seen_reg |-> gap_reg == SAMPLE_DIV - 1)
      else $error("sample spacing wrong");
   a_ov_flag: assert property (i_overvolt |=> o_status[0])
      else $error("overvoltage flag missing");
   a_ov_clear: assert property (!i_overvolt |=> !o_status[0])
      else $error("overvoltage flag stuck");
   a_ov_off: assert property (i_overvolt |=> !o_drive_oe)
      else $error("output on during overvoltage");
   a_fixed_flag: assert property (i_par_err |-> ##2 o_status[1])
      else $error("memory error flag missing");
   a_fatal_keep: assert property (o_status[2] |=> o_status[2] ##1 !o_drive_oe)
      else $error("fatal error released");
endmodule : hfd_conditioning_properties

// ===== bench/hfd_frame_sink.sv
// Receiving controller model: keeps the last result frame and a frame count.
// Assumes the result is steady while the valid pulse is high.
`timescale 1ns/1ns
module hfd_frame_sink (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire logic [15:0] i_result,
   output logic [15:0] o_last_result,
   output logic [31:0] o_frames
);
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_last_result <= 16'h0000;
         o_frames <= 32'h0;
      end else if (i_valid) begin
         o_last_result <= i_result;
         o_frames <= o_frames + 32'h1;
      end
   end
endmodule : hfd_frame_sink

// ===== src/hfd_conditioning.sv
// Digital conditioning chain of the Hall field sensor: span select, filter, gain,
// offset, clamping and self diagnostics. Assumes converter samples arrive
// synchronous to the core clock and the programmer loads sane settings.
// Functional notes
// - Span codes 3, 1, 0 select 50, 100, 200 mT converter spans.
// - Span code 2 drives the converter like code 1, but the span register reads back 2.
// - Every span is symmetric around zero field.
// - Gain is multiplier code minus 16384 over 4096, signed.
// - Offset is offset code minus 16384 in output LSB steps.
// - Bandwidth code picks one of five filter shifts; code 7 bypasses.
// - Codes 0..6 map to shifts 7, 6, 5, 4, 4, 3, 3; codes 3/4 and 5/6 match.
// - Filter has unity gain at DC for every setting.
// - Filter delivers samples downstream at 16 kHz.
// - Lower clamp is code times 1024; code zero disables it.
// - Upper clamp is code plus one times 1024 minus one; 63 disables.
// - Out-of-range results are limited to the active clamp value.
// - Diagnostic errors are reported in a four-bit status nibble.
// - Overvoltage sets its status bit and turns the output off.
// - One bad line is corrected; a second bad line is detected.
// - Uncorrectable memory error turns the output off permanently.
// - Order is filter, gain, offset, then limiting.
// - Result is limited to 16 bits before output.
`timescale 1ns/1ns
module hfd_conditioning #(
   parameter int ADC_W = 16,
   parameter int SAMPLE_DIV = hfd_pkg::SAMPLE_CYCLES,
   parameter int LINE_W = 4
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic signed [ADC_W-1:0] i_adc_sample,
   input wire logic i_overvolt,
   input wire logic i_par_err,
   input wire logic [LINE_W-1:0] i_par_line,
   output logic [1:0] o_adc_span,
   output logic o_result_valid,
   output logic [15:0] o_result,
   output logic [3:0] o_status,
   output logic o_drive_oe
);
   initial begin
      if (ADC_W < 8 || ADC_W > 20) $error("hfd_conditioning ADC width unsupported");
      if (SAMPLE_DIV < 2) $error("hfd_conditioning sample divider too small");
      // The divider counter is 16 bits wide
      if (SAMPLE_DIV > 65536) $error("hfd_conditioning sample divider too large");
      if (LINE_W < 1) $error("hfd_conditioning line width too small");
   end

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_GAIN = 4'h2,
      ST_OFFS = 4'h4,
      ST_LIMIT = 4'h8
   } hfd_state_t;

   // Control registers
   logic [1:0] span_reg;
   logic [14:0] gain_reg;
   logic [14:0] offset_reg;
   logic [2:0] bw_reg;
   logic [5:0] lo_reg;
   logic [5:0] hi_reg;

   // One process per register; writes to other indices leave it alone
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         span_reg <= hfd_pkg::SPAN_RESET;
      end else if (i_wr && i_addr == hfd_pkg::ADDR_SPAN) begin
         span_reg <= i_wdata[1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         gain_reg <= hfd_pkg::GAIN_RESET;
      end else if (i_wr && i_addr == hfd_pkg::ADDR_GAIN) begin
         gain_reg <= i_wdata[14:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         offset_reg <= hfd_pkg::OFFSET_RESET;
      end else if (i_wr && i_addr == hfd_pkg::ADDR_OFFSET) begin
         offset_reg <= i_wdata[14:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         bw_reg <= hfd_pkg::BW_RESET;
      end else if (i_wr && i_addr == hfd_pkg::ADDR_BW) begin
         bw_reg <= i_wdata[2:0];
      end
   end

   // Both clamp codes share one index so they change together
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         lo_reg <= hfd_pkg::LO_RESET;
      end else if (i_wr && i_addr == hfd_pkg::ADDR_LIMIT) begin
         lo_reg <= i_wdata[hfd_pkg::LIMIT_LO_POS +: 6];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         hi_reg <= hfd_pkg::HI_RESET;
      end else if (i_wr && i_addr == hfd_pkg::ADDR_LIMIT) begin
         hi_reg <= i_wdata[hfd_pkg::LIMIT_HI_POS +: 6];
      end
   end

   // Unused code 2 folds to mid span so the converter never sees it
   function automatic logic [1:0] span_map(input logic [1:0] code);
      span_map = (code == hfd_pkg::SPAN_UNUSED) ? hfd_pkg::SPAN_MID : code;
   endfunction : span_map

   // Span output drives the converter; each code is a symmetric +/- range
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_adc_span <= hfd_pkg::SPAN_MID;
      end else begin
         o_adc_span <= span_map(span_reg);
      end
   end

   // Sample rate divider
   logic [15:0] div_reg;
   logic strobe_reg;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         div_reg <= '0;
      end else if (div_reg == 16'(SAMPLE_DIV - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end

   // Strobe rises the cycle after the count reaches its end
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= (div_reg == 16'(SAMPLE_DIV - 1));
      end
   end

   logic signed [ADC_W-1:0] filt;
   hfd_lowpass #(.W(ADC_W)) u_lowpass (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_strobe(strobe_reg),
      .i_bw(bw_reg),
      .i_sample(i_adc_sample),
      .o_sample(filt)
   );

   // Filter output settles two cycles after the strobe
   logic strobe_d_reg;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         strobe_d_reg <= 1'b0;
      end else begin
         strobe_d_reg <= strobe_reg;
      end
   end

   // Saturate instead of wrapping, so a large product cannot fold back into range
   function automatic logic [15:0] sat16(input logic signed [40:0] v);
      if (v < 0) begin
         sat16 = 16'h0000;
      end else if (v > 41'sd65535) begin
         sat16 = 16'hFFFF;
      end else begin
         sat16 = v[15:0];
      end
   endfunction : sat16

   // Pipeline: multiply, add offset, clamp; one stage per state
   hfd_state_t state_reg;
   logic signed [40:0] prod_reg;
   logic [15:0] sum_reg;
   logic signed [15:0] gain_s;
   logic signed [15:0] offs_s;
   logic signed [40:0] offs_sum;
   logic [15:0] lo_val;
   logic [15:0] hi_val;
   logic [15:0] limited;
   logic hit_clamp;

   assign gain_s = signed'({1'b0, gain_reg}) - signed'({1'b0, hfd_pkg::CODE_BIAS});
   assign offs_s = signed'({1'b0, offset_reg}) - signed'({1'b0, hfd_pkg::CODE_BIAS});
   assign offs_sum = prod_reg + 41'(offs_s);
   assign lo_val = 16'({10'h000, lo_reg} << hfd_pkg::LIMIT_STEP_SHIFT);
   assign hi_val = 16'(({10'h000, hi_reg} + 16'h0001) << hfd_pkg::LIMIT_STEP_SHIFT)
      - 16'h0001;

   // Lower clamp wins; with legal settings both can never apply at once
   always_comb begin
      limited = sum_reg;
      hit_clamp = 1'b0;
      if (lo_reg != hfd_pkg::LO_OFF && sum_reg < lo_val) begin
         limited = lo_val;
         hit_clamp = 1'b1;
      end else if (hi_reg != hfd_pkg::HI_OFF && sum_reg > hi_val) begin
         limited = hi_val;
         hit_clamp = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (strobe_d_reg) begin
                  state_reg <= ST_GAIN;
               end
            end
            ST_GAIN: state_reg <= ST_OFFS;
            ST_OFFS: state_reg <= ST_LIMIT;
            ST_LIMIT: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Product scaled down by the 1/4096 gain step
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         prod_reg <= '0;
      end else if (state_reg == ST_GAIN) begin
         prod_reg <= (41'(filt) * 41'(gain_s)) >>> hfd_pkg::GAIN_FRAC;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         sum_reg <= '0;
      end else if (state_reg == ST_OFFS) begin
         sum_reg <= sat16(offs_sum);
      end
   end

   logic clamped_reg;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_result_valid <= 1'b0;
      end else begin
         o_result_valid <= (state_reg == ST_LIMIT);
      end
   end

   // Result holds between pulses so a slow reader still sees it
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_result <= '0;
      end else if (state_reg == ST_LIMIT) begin
         o_result <= limited;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         clamped_reg <= 1'b0;
      end else if (state_reg == ST_LIMIT) begin
         clamped_reg <= hit_clamp;
      end
   end

   // Diagnostics
   logic mem_fixed;
   logic mem_fatal;
   hfd_memcheck #(.LW(LINE_W)) u_memcheck (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_par_err(i_par_err),
      .i_par_line(i_par_line),
      .o_fixed(mem_fixed),
      .o_fatal(mem_fatal)
   );

   // Overvoltage follows the input; it is not sticky
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_status[hfd_pkg::ST_OVERVOLT] <= 1'b0;
      end else begin
         o_status[hfd_pkg::ST_OVERVOLT] <= i_overvolt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_status[hfd_pkg::ST_MEM_FIXED] <= 1'b0;
         o_status[hfd_pkg::ST_MEM_FATAL] <= 1'b0;
         o_status[hfd_pkg::ST_CLAMPED] <= 1'b0;
      end else begin
         o_status[hfd_pkg::ST_MEM_FIXED] <= mem_fixed;
         o_status[hfd_pkg::ST_MEM_FATAL] <= mem_fatal;
         o_status[hfd_pkg::ST_CLAMPED] <= clamped_reg;
      end
   end

   // Output stage enable: released only when neither fault is present.
   // Fatal memory error is latched, so the stage stays off until reset.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_drive_oe <= 1'b0;
      end else begin
         o_drive_oe <= !i_overvolt && !mem_fatal;
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         case (i_addr)
            hfd_pkg::ADDR_SPAN: o_rdata <= {30'h0, span_reg};
            hfd_pkg::ADDR_GAIN: o_rdata <= {17'h0, gain_reg};
            hfd_pkg::ADDR_OFFSET: o_rdata <= {17'h0, offset_reg};
            hfd_pkg::ADDR_BW: o_rdata <= {29'h0, bw_reg};
            hfd_pkg::ADDR_LIMIT: o_rdata <= {18'h0, hi_reg, 2'h0, lo_reg};
            hfd_pkg::ADDR_STATUS: o_rdata <= {28'h0, o_status};
            hfd_pkg::ADDR_RESULT: o_rdata <= {16'h0, o_result};
            hfd_pkg::ADDR_MEM: o_rdata <= {30'h0, mem_fatal, mem_fixed};
            default: o_rdata <= 32'h0;
         endcase
      end else begin
         o_rdata <= 32'h0;
      end
   end
endmodule : hfd_conditioning

// ===== src/hfd_lowpass.sv
// First-order low-pass filter with selectable coefficient.
// Assumes one input sample per strobe; output updates two cycles after the strobe.
`timescale 1ns/1ns
module hfd_lowpass #(
   parameter int W = 16
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_strobe,
   input wire logic [2:0] i_bw,
   input wire logic signed [W-1:0] i_sample,
   output logic signed [W-1:0] o_sample
);
   initial begin
      if (W < 4) $error("hfd_lowpass width too small");
   end
   // Shift k gives alpha = 2^-k; larger shift is a lower cutoff
   function automatic logic [3:0] bw_shift(input logic [2:0] bw);
      case (bw)
         3'h0: bw_shift = 4'h7;
         3'h1: bw_shift = 4'h6;
         3'h2: bw_shift = 4'h5;
         3'h3: bw_shift = 4'h4;
         3'h4: bw_shift = 4'h4;
         3'h5: bw_shift = 4'h3;
         3'h6: bw_shift = 4'h3;
         default: bw_shift = 4'h0;
      endcase
   endfunction : bw_shift
   // Accumulator keeps fraction bits so DC gain is exactly one
   logic signed [W+7:0] acc_reg;
   logic signed [W+7:0] in_ext;
   logic signed [W+7:0] diff;
   logic signed [W+7:0] step;
   assign in_ext = {i_sample, 8'h00};
   assign diff = in_ext - acc_reg;
   // Plain truncation would park the output one LSB low after a rising step
   always_comb begin
      step = diff >>> bw_shift(i_bw);
      if (step == '0 && diff > 0) begin
         step = (W+8)'(1);
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         acc_reg <= '0;
      end else if (i_strobe) begin
         if (i_bw == hfd_pkg::BW_OFF) begin
            acc_reg <= in_ext;
         end else begin
            acc_reg <= acc_reg + step;
         end
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_sample <= '0;
      end else begin
         o_sample <= acc_reg[W+7:8];
      end
   end
endmodule : hfd_lowpass

// ===== src/hfd_memcheck.sv
// Memory parity monitor: latches single and uncorrectable error indications.
// Assumes the memory row checker pulses an error per line with its line number.
`timescale 1ns/1ns
module hfd_memcheck #(
   parameter int LW = 4
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_par_err,
   input wire logic [LW-1:0] i_par_line,
   output logic o_fixed,
   output logic o_fatal
);
   initial begin
      if (LW < 1) $error("hfd_memcheck line width too small");
   end
   logic [LW-1:0] line_reg;
   // Fatal is permanent until reset; nothing in software can clear it
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         o_fixed <= 1'b0;
         o_fatal <= 1'b0;
         line_reg <= '0;
      end else if (i_par_err) begin
         if (!o_fixed) begin
            o_fixed <= 1'b1;
            line_reg <= i_par_line;
         end else if (i_par_line != line_reg) begin
            o_fatal <= 1'b1;
         end
      end
   end
endmodule : hfd_memcheck

// ===== src/hfd_pkg.sv
// Package: register map, field widths, reset values and timing constants for the
// field conditioning chain. Assumes a 100 MHz core clock.
package hfd_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] ADDR_SPAN = 4'h0;
   localparam logic [3:0] ADDR_GAIN = 4'h1;
   localparam logic [3:0] ADDR_OFFSET = 4'h2;
   localparam logic [3:0] ADDR_BW = 4'h3;
   localparam logic [3:0] ADDR_LIMIT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_RESULT = 4'h6;
   localparam logic [3:0] ADDR_MEM = 4'h7;
   // Field positions inside the limit register
   localparam int LIMIT_LO_POS = 0;
   localparam int LIMIT_HI_POS = 8;
   // Values after reset: mid span, unity gain, zero offset, filter off, clamps off
   localparam logic [1:0] SPAN_RESET = 2'h1;
   localparam logic [14:0] GAIN_RESET = 15'h5000;
   localparam logic [14:0] OFFSET_RESET = 15'h4000;
   localparam logic [2:0] BW_RESET = 3'h7;
   localparam logic [5:0] LO_RESET = 6'h00;
   localparam logic [5:0] HI_RESET = 6'h3F;
   // Span codes
   localparam logic [1:0] SPAN_LOW = 2'h3;
   localparam logic [1:0] SPAN_MID = 2'h1;
   localparam logic [1:0] SPAN_UNUSED = 2'h2;
   localparam logic [1:0] SPAN_HIGH = 2'h0;
   localparam logic [2:0] BW_OFF = 3'h7;
   localparam logic [14:0] CODE_BIAS = 15'h4000;
   localparam int GAIN_FRAC = 12;
   localparam logic [5:0] LIMIT_STEP_SHIFT = 6'hA;
   localparam logic [5:0] HI_OFF = 6'h3F;
   localparam logic [5:0] LO_OFF = 6'h00;
   // Status nibble bit positions
   localparam int ST_OVERVOLT = 0;
   localparam int ST_MEM_FIXED = 1;
   localparam int ST_MEM_FATAL = 2;
   localparam int ST_CLAMPED = 3;
   // Sample rate after the filter
   localparam int CLK_HZ = 100_000_000;
   localparam int SAMPLE_HZ = 16_000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   // Nominal cutoff in Hz per bandwidth code 0..6; the filter shifts do not use this table
   localparam int CUTOFF_HZ [7] = '{80, 240, 440, 640, 860, 1100, 1390};
endpackage : hfd_pkg
